// [dmba_addr_gen.sv]
// dmba_addr_gen: forms data memory addresses from operands, pointers and bank state
// assumes: the execution unit issues one access per accStb pulse with stable operands;
// H, L, D, E and stack pointer come from the core's register file
//
// Notes on behaviour
// - decode RAM, display and peripheral regions
// - address is bank nibble over low byte
// - bank select holds 0,1,2,3 or 15
// - bank enable saved on call, restored on return
// - direct mode without enable: low half 0, high 15
// - byte direct uses even operand, byte pair
// - HL nibble indirect bank is enable AND select
// - HL post inc/dec changes only L
// - DE and DL indirect always bank 0
// - HL byte indirect ignores L bit 0
// - fixed bit reaches FB0-FBF and FF0-FFF only
// - port bit uses pmem high bits and L
// - H-relative bit uses bank, H, mem low
// - stack uses pointer within banks 0 to 3
`timescale 1ns/1ps
module dmba_addr_gen
  import dmba_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // bank control from the core
  input  wire logic             bankEnWrStb,
  input  wire logic             bankEnWrData,
  input  wire logic             bankSelWrStb,
  input  wire logic [3:0]       bankSelWrData,
  input  wire logic             stkBankWrStb,
  input  wire logic [1:0]       stkBankWrData,
  input  wire logic             enterStb,
  input  wire logic             returnStb,
  // access request
  input  wire logic             accStb,
  input  wire logic             accWrite,
  input  wire dmba_pkg::dmba_mode_t accMode,
  input  wire logic [7:0]       operand,
  input  wire logic [1:0]       bitSelIn,
  input  wire logic [3:0]       regH,
  input  wire logic [3:0]       regL,
  input  wire logic [3:0]       regD,
  input  wire logic [3:0]       regE,
  input  wire logic [7:0]       stackPointer,
  // results
  output logic [11:0]           memAddr,
  output logic [1:0]            bitSel,
  output logic                  byteAccess,
  output logic                  memRdEn,
  output logic                  memWrEn,
  output logic                  regionRam,
  output logic                  regionDisp,
  output logic                  regionPeri,
  output logic                  accFault,
  output logic                  lUpdStb,
  output logic [3:0]            lNewValue,
  output logic                  bankEnableFlag,
  output logic [3:0]            bankSelectValue,
  output logic [1:0]            stackBankSelect,
  output logic [3:0]            effectiveBank
);
  import dmba_pkg::*;

  // ==========================================================
  // bank state
  logic                  bankEn_r;
  logic [3:0]            bankSel_r;
  logic [1:0]            stkBank_r;
  logic [SAVE_DEPTH-1:0] saveStk_r;
  logic [SAVE_PTR_W-1:0] savePtr_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bankSel_r <= BANK_SEL_RST;
    end else if (bankSelWrStb) begin
      if (bankSelWrData <= BANK_MAXRAM || bankSelWrData == BANK_PERI) begin
        bankSel_r <= bankSelWrData;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stkBank_r <= STK_BANK_RST;
    end else if (stkBankWrStb) begin
      stkBank_r <= stkBankWrData;
    end
  end

  // enable flag with save on entry and restore on return
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bankEn_r  <= BANK_EN_RST;
      saveStk_r <= '0;
      savePtr_r <= '0;
    end else if (enterStb) begin
      saveStk_r[savePtr_r] <= bankEn_r;
      savePtr_r            <= savePtr_r + 1'b1;
    end else if (returnStb) begin
      bankEn_r  <= saveStk_r[savePtr_r - 1'b1];
      savePtr_r <= savePtr_r - 1'b1;
    end else if (bankEnWrStb) begin
      bankEn_r <= bankEnWrData;
    end
  end

  // ==========================================================
  // address formation
  logic [3:0]  bankDirect;
  logic [3:0]  bankAnd;
  logic [11:0] addrNxt;
  logic [1:0]  bitNxt;
  logic        byteNxt;
  logic        lUpdNxt;
  logic [3:0]  lNxt;

  always_comb begin
    bankDirect = bankEn_r ? bankSel_r : (operand[7] ? BANK_PERI : BANK_ZERO);
    bankAnd    = bankSel_r & {4{bankEn_r}};
    addrNxt    = {BANK_ZERO, operand};
    bitNxt     = bitSelIn;
    byteNxt    = 1'b0;
    lUpdNxt    = 1'b0;
    lNxt       = regL;
    unique case (accMode)
      DMBA_BIT_DIRECT,
      DMBA_NIB_DIRECT: addrNxt = {bankDirect, operand};
      DMBA_BYTE_DIRECT: begin
        addrNxt = {bankDirect, operand[7:1], 1'b0};
        byteNxt = 1'b1;
      end
      DMBA_NIB_HL: addrNxt = {bankAnd, regH, regL};
      DMBA_NIB_HL_INC: begin
        addrNxt = {bankAnd, regH, regL};
        lUpdNxt = 1'b1;
        lNxt    = regL + 4'h1;
      end
      DMBA_NIB_HL_DEC: begin
        addrNxt = {bankAnd, regH, regL};
        lUpdNxt = 1'b1;
        lNxt    = regL - 4'h1;
      end
      DMBA_NIB_DE: addrNxt = {BANK_ZERO, regD, regE};
      DMBA_NIB_DL: addrNxt = {BANK_ZERO, regD, regL};
      DMBA_BYTE_HL: begin
        addrNxt = {bankAnd, regH, regL[3:1], 1'b0};
        byteNxt = 1'b1;
      end
      DMBA_BIT_FIXED: begin
        // bit 6 of operand picks port block, else interrupt block
        addrNxt = operand[6] ? {FIX_PORT_LO[11:4], operand[3:0]}
                             : {FIX_INT_LO[11:4], operand[3:0]};
      end
      DMBA_BIT_PORT: begin
        addrNxt = {PBIT_LO[11:6], operand[5:2], regL[3:2]};
        bitNxt  = regL[1:0];
      end
      DMBA_BIT_HREL: addrNxt = {bankAnd, regH, operand[3:0]};
      DMBA_STACK: addrNxt = {2'b00, stkBank_r, stackPointer};
      default: addrNxt = {BANK_ZERO, operand};
    endcase
  end

  // ==========================================================
  // region check and registered outputs
  logic isRam;
  logic isDisp;
  logic isPeri;
  logic isHole;

  dmba_region_decode uDecode (
    .addr   (addrNxt),
    .isRam  (isRam),
    .isDisp (isDisp),
    .isPeri (isPeri),
    .isHole (isHole)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      memAddr    <= '0;
      bitSel     <= '0;
      byteAccess <= 1'b0;
      regionRam  <= 1'b0;
      regionDisp <= 1'b0;
      regionPeri <= 1'b0;
      accFault   <= 1'b0;
      memRdEn    <= 1'b0;
      memWrEn    <= 1'b0;
    end else begin
      memRdEn <= accStb && !accWrite && !isHole;
      memWrEn <= accStb && accWrite && !isHole;
      accFault <= accStb && isHole;
      if (accStb) begin
        memAddr    <= addrNxt;
        bitSel     <= bitNxt;
        byteAccess <= byteNxt;
        regionRam  <= isRam;
        regionDisp <= isDisp;
        regionPeri <= isPeri;
      end
    end
  end

  // L update issued in the same cycle the access address is latched
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lUpdStb   <= 1'b0;
      lNewValue <= '0;
    end else begin
      lUpdStb <= accStb && lUpdNxt;
      if (accStb && lUpdNxt) begin
        lNewValue <= lNxt;
      end
    end
  end

  assign bankEnableFlag  = bankEn_r;
  assign bankSelectValue = bankSel_r;
  assign stackBankSelect = stkBank_r;
  assign effectiveBank   = bankAnd;

endmodule

// [dmba_core_regs.sv]
// dmba_core_regs: core register file model holding L
// assumes: bench loads L, block returns post inc/dec values
`timescale 1ns/1ps
module dmba_core_regs (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ldStb,
  input  wire logic [3:0] ldVal,
  input  wire logic       lUpdStb,
  input  wire logic [3:0] lNewValue,
  output logic      [3:0] regL
);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) regL <= 4'h0;
    else if (ldStb) regL <= ldVal;
    else if (lUpdStb) regL <= lNewValue;
  end
endmodule

// [dmba_pkg.sv]
// dmba_pkg: constants and types for the data memory bank addressing block
// assumes: 12-bit data address space, 4-bit banks, 8-bit low address byte
package dmba_pkg;

  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;

  // address regions
  localparam logic [11:0] RAM0_LO    = 12'h000;
  localparam logic [11:0] RAM0_HI    = 12'h19f;
  localparam logic [11:0] DISP_LO    = 12'h1a0;
  localparam logic [11:0] DISP_HI    = 12'h1ff;
  localparam logic [11:0] RAM1_LO    = 12'h200;
  localparam logic [11:0] RAM1_HI    = 12'h3ff;
  localparam logic [11:0] PERI_LO    = 12'hf80;
  localparam logic [11:0] PERI_HI    = 12'hfff;
  localparam logic [11:0] FIX_INT_LO = 12'hfb0;
  localparam logic [11:0] FIX_PORT_LO = 12'hff0;
  localparam logic [11:0] PBIT_LO    = 12'hfc0;

  // bank values
  localparam logic [3:0] BANK_ZERO  = 4'h0;
  localparam logic [3:0] BANK_PERI  = 4'hf;
  localparam logic [3:0] BANK_MAXRAM = 4'h3;

  // reset values
  localparam logic [3:0] BANK_SEL_RST  = 4'h0;
  localparam logic [1:0] STK_BANK_RST  = 2'h0;
  localparam logic       BANK_EN_RST   = 1'b0;

  // save stack depth for the bank enable flag
  localparam int SAVE_DEPTH = 16;
  localparam int SAVE_PTR_W = 4;

  typedef enum logic [3:0] {
    DMBA_BIT_DIRECT,
    DMBA_NIB_DIRECT,
    DMBA_BYTE_DIRECT,
    DMBA_NIB_HL,
    DMBA_NIB_HL_INC,
    DMBA_NIB_HL_DEC,
    DMBA_NIB_DE,
    DMBA_NIB_DL,
    DMBA_BYTE_HL,
    DMBA_BIT_FIXED,
    DMBA_BIT_PORT,
    DMBA_BIT_HREL,
    DMBA_STACK
  } dmba_mode_t;

endpackage

// [dmba_properties.sv]
// dmba_properties: port checker for dmba_addr_gen
// assumes: one clock domain, bound to every dmba_addr_gen
`timescale 1ns/1ps
module dmba_properties
  import dmba_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 accStb,
  input wire dmba_pkg::dmba_mode_t accMode,
  input wire logic [7:0]           operand,
  input wire logic [3:0]           regL,
  input wire logic [3:0]           regD,
  input wire logic [3:0]           regE,
  input wire logic [7:0]           stackPointer,
  input wire logic [11:0]          memAddr,
  input wire logic                 byteAccess,
  input wire logic                 memRdEn,
  input wire logic                 memWrEn,
  input wire logic                 accFault,
  input wire logic                 lUpdStb,
  input wire logic [3:0]           lNewValue,
  input wire logic                 bankEnableFlag,
  input wire logic [3:0]           bankSelectValue,
  input wire logic [1:0]           stackBankSelect,
  input wire logic [3:0]           effectiveBank
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // bank state
  a_sel_legal: assert property (bankSelectValue inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hf})
    else $error("bank select holds an illegal value");
  a_eff_bank: assert property (effectiveBank == (bankEnableFlag ? bankSelectValue : 4'h0))
    else $error("effective bank not flag and select");
  // ==========================================
  // address forming
  a_direct_low: assert property (accStb && accMode == DMBA_NIB_DIRECT && !bankEnableFlag
    && !operand[7] |=> memAddr == {4'h0, $past(operand)}) else $error("direct low bank wrong");
  a_de_bank: assert property (accStb && accMode == DMBA_NIB_DE
    |=> memAddr == {4'h0, $past(regD), $past(regE)}) else $error("pointer pair bank wrong");
  a_hl_bank: assert property (accStb && accMode == DMBA_NIB_HL
    |=> memAddr[11:8] == ($past(bankEnableFlag) ? $past(bankSelectValue) : 4'h0))
    else $error("pointer bank not flag and select");
  a_port_range: assert property (accStb && accMode == DMBA_BIT_PORT
    |=> memAddr[11:6] == 6'h3f) else $error("port bit address out of range");
  a_inc_l: assert property (accStb && accMode == DMBA_NIB_HL_INC
    |=> lUpdStb && lNewValue == $past(regL) + 4'h1) else $error("post increment wrong");
  a_fixed_range: assert property (accStb && accMode == DMBA_BIT_FIXED
    |=> memAddr[11:4] inside {8'hfb, 8'hff}) else $error("fixed bit out of range");
  a_stack_bank: assert property (accStb && accMode == DMBA_STACK
    |=> memAddr == {2'h0, $past(stackBankSelect), $past(stackPointer)}) else $error("stack bad");
  a_byte_even: assert property (byteAccess |-> !memAddr[0])
    else $error("byte access on odd address");
  a_fault_quiet: assert property (accFault |-> !memRdEn && !memWrEn)
    else $error("access enabled on unpopulated space");
  c_fault: cover property (accFault);
  c_inc: cover property (lUpdStb);
  c_byte: cover property (byteAccess && memRdEn);
endmodule
bind dmba_addr_gen dmba_properties u_dmba_properties (.*);

// [dmba_region_decode.sv]
// dmba_region_decode: classifies a 12-bit data address into memory regions
// assumes: purely combinational, fed by the address generator
`timescale 1ns/1ps
module dmba_region_decode
  import dmba_pkg::*;
(
  input  wire logic [11:0] addr,
  output logic             isRam,
  output logic             isDisp,
  output logic             isPeri,
  output logic             isHole
);
  import dmba_pkg::*;

  always_comb begin
    isRam  = (addr <= RAM0_HI) || (addr >= RAM1_LO && addr <= RAM1_HI);
    isDisp = (addr >= DISP_LO) && (addr <= DISP_HI);
    isPeri = (addr >= PERI_LO);
    isHole = !(isRam || isDisp || isPeri);
  end

endmodule

// [dmba_tb.sv]
// dmba_tb: self-checking bench for dmba_addr_gen
// assumes: inputs change on falling edge, answers one cycle later
`timescale 1ns/1ps
module testbench;
  import dmba_pkg::*;
  logic       sys_clk = '0, rst_n = '0, bankEnWrStb = '0, bankEnWrData = '0, ldStb = '0;
  logic       bankSelWrStb = '0, stkBankWrStb = '0, enterStb = '0, returnStb = '0;
  logic       accStb = '0, accWrite = '0, byteAccess, memRdEn, memWrEn, regionRam;
  logic       regionDisp, regionPeri, accFault, lUpdStb, bankEnableFlag;
  logic [3:0] bankSelWrData = '0, regH = '0, regD = '0, regE = '0, ldVal = '0;
  logic [3:0] regL, lNewValue, bankSelectValue, effectiveBank;
  logic [1:0] stkBankWrData = '0, bitSelIn = '0, bitSel, stackBankSelect;
  logic [7:0] operand = '0, stackPointer = '0;
  logic [11:0] memAddr;
  dmba_mode_t accMode = DMBA_BIT_DIRECT;
  int failures = 0, num_checks = 0, cyc = 0;
  dmba_addr_gen u_dmba_addr_gen (.*);
  dmba_core_regs u_dmba_core_regs (.*);
  always #2.5 sys_clk = ~sys_clk;
  // ==========================================
  // helpers
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'h1;
    @(negedge sys_clk) s = 1'h0;
  endtask
  task automatic bk(logic e, logic [3:0] s);
    @(negedge sys_clk);
    bankEnWrData = e;
    bankSelWrData = s;
    bankSelWrStb = 1'h1;
    bankEnWrStb = 1'h1;
    @(negedge sys_clk);
    bankSelWrStb = 1'h0;
    bankEnWrStb = 1'h0;
  endtask
  task automatic setl(logic [3:0] v);
    ldVal = v;
    pulse(ldStb);
  endtask
  task automatic acc(dmba_mode_t m, logic [7:0] op, logic w);
    accMode = m;
    operand = op;
    accWrite = w;
    pulse(accStb);
  endtask
  // ==========================================
  // scenarios
  task automatic t_direct;
    bk(1'h0, 4'h0);
    acc(DMBA_NIB_DIRECT, 8'h12, 1'h0);
    chk(memAddr, 12'h012);
    chk(regionRam, 12'h1);
    acc(DMBA_NIB_DIRECT, 8'h85, 1'h0);
    chk(memAddr, 12'hf85);
    chk(regionPeri, 12'h1);
    bk(1'h1, 4'h2);
    acc(DMBA_BYTE_DIRECT, 8'h34, 1'h0);
    chk({byteAccess, memAddr}, 13'h1234);
    bk(1'h1, 4'h5);
    chk(bankSelectValue, 12'h2);
    bk(1'h1, 4'hf);
    acc(DMBA_NIB_DIRECT, 8'h10, 1'h1);
    chk({accFault, memWrEn}, 12'h2);
    acc(DMBA_NIB_DIRECT, 8'h20, 1'h0);
    chk({accFault, memRdEn}, 12'h2);
    bk(1'h1, 4'h1);
    chk(effectiveBank, 12'h1);
    acc(DMBA_BIT_DIRECT, 8'ha5, 1'h0);
    chk(memAddr, 12'h1a5);
    chk({regionDisp, regionRam, memRdEn}, 12'h5);
  endtask
  task automatic t_hl;
    bk(1'h1, 4'h3);
    regH = 4'h2;
    setl(4'hf);
    acc(DMBA_NIB_HL_INC, 8'h00, 1'h0);
    chk({memRdEn, memAddr}, 13'h132f);
    chk({lUpdStb, lNewValue}, 12'h10);
    @(negedge sys_clk);
    chk(regL, 12'h0);
    acc(DMBA_NIB_HL_DEC, 8'h00, 1'h0);
    @(negedge sys_clk);
    chk({memAddr, regL}, 16'h320f);
    bk(1'h0, 4'h3);
    acc(DMBA_NIB_HL, 8'h00, 1'h0);
    chk(memAddr, 12'h02f);
  endtask
  task automatic t_ptr;
    bk(1'h1, 4'h3);
    regD = 4'h1;
    regE = 4'h2;
    acc(DMBA_NIB_DE, 8'h00, 1'h0);
    chk(memAddr, 12'h012);
    acc(DMBA_NIB_DL, 8'h00, 1'h0);
    chk(memAddr, 12'h01f);
    setl(4'h5);
    acc(DMBA_BYTE_HL, 8'h00, 1'h0);
    chk(memAddr, 12'h324);
  endtask
  task automatic t_bit;
    acc(DMBA_BIT_FIXED, 8'h43, 1'h0);
    chk(memAddr, 12'hff3);
    acc(DMBA_BIT_FIXED, 8'h05, 1'h0);
    chk(memAddr, 12'hfb5);
    setl(4'h6);
    acc(DMBA_BIT_PORT, 8'h0c, 1'h0);
    chk({bitSel, memAddr}, 14'h2fcd);
    bk(1'h1, 4'h1);
    regH = 4'h4;
    bitSelIn = 2'h3;
    acc(DMBA_BIT_HREL, 8'h97, 1'h0);
    chk({bitSel, memAddr}, 14'h3147);
  endtask
  task automatic t_stack;
    stkBankWrData = 2'h2;
    pulse(stkBankWrStb);
    chk(stackBankSelect, 12'h2);
    stackPointer = 8'h34;
    acc(DMBA_STACK, 8'h00, 1'h1);
    chk(memAddr, 12'h234);
    bk(1'h1, 4'h3);
    pulse(enterStb);
    chk(bankEnableFlag, 12'h1);
    bk(1'h0, 4'h3);
    chk(bankEnableFlag, 12'h0);
    pulse(returnStb);
    chk(bankEnableFlag, 12'h1);
  endtask
  task automatic t_reset;
    @(negedge sys_clk) rst_n = 1'h0;
    @(negedge sys_clk) rst_n = 1'h1;
    chk({bankEnableFlag, bankSelectValue}, {BANK_EN_RST, BANK_SEL_RST});
    chk(stackBankSelect, STK_BANK_RST);
    chk(memAddr, 12'h0);
    acc(DMBA_NIB_DIRECT, 8'h85, 1'h0);
    chk(memAddr, 12'hf85);
  endtask
  // ==========================================
  // run control
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'h1;
    t_direct();
    t_hl();
    t_ptr();
    t_bit();
    t_stack();
    t_reset();
    stop_test();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      stop_test();
    end
  end
endmodule
